//--- hdl/tcr_defs.vh
`ifndef TCR_DEFS_VH
`define TCR_DEFS_VH

// ****************************************************************
// Two-wire addressing
// ****************************************************************
// Upper six bits of the seven-bit slave address; the address pin
// supplies the lowest bit.
`define TCR_SLAVE_ADDR_HI    6'h30

// ****************************************************************
// Register offsets on the two-wire bus
// ****************************************************************
`define TCR_OFS_REF_CLOCK_DIVIDERS     8'h05
`define TCR_OFS_SYNTH_PUMP_CONFIG      8'h06
`define TCR_OFS_OSCILLATOR_BAND_SELECT 8'h07
`define TCR_OFS_FILTER_CORNER          8'h08
`define TCR_OFS_GAIN_AND_STANDBY       8'h09
`define TCR_OFS_BLOCK_POWER_DOWN       8'h0A
`define TCR_OFS_TEST_MODES             8'h0B

// ****************************************************************
// Reset values
// ****************************************************************
`define TCR_RST_REF_CLOCK_DIVIDERS     8'h04
`define TCR_RST_SYNTH_PUMP_CONFIG      8'hC0
`define TCR_RST_OSCILLATOR_BAND_SELECT 8'hCC
`define TCR_RST_FILTER_CORNER          8'h4B
`define TCR_RST_GAIN_AND_STANDBY       8'h00
`define TCR_RST_BLOCK_POWER_DOWN       8'h00
`define TCR_RST_TEST_MODES             8'h08

// ****************************************************************
// Writable bit masks; cleared bits are don't-care and stored as zero
// ****************************************************************
`define TCR_MSK_REF_CLOCK_DIVIDERS     8'hFF
`define TCR_MSK_SYNTH_PUMP_CONFIG      8'hE0
`define TCR_MSK_OSCILLATOR_BAND_SELECT 8'hFF
`define TCR_MSK_FILTER_CORNER          8'hFF
`define TCR_MSK_GAIN_AND_STANDBY       8'hAF
`define TCR_MSK_BLOCK_POWER_DOWN       8'h7F
`define TCR_MSK_TEST_MODES             8'hEF

// ****************************************************************
// Field positions
// ****************************************************************
`define TCR_XDIV_MSB       7
`define TCR_XDIV_LSB       5
`define TCR_RDIV_MSB       4
`define TCR_RDIV_LSB       0
`define TCR_POSTDIV_BIT    7
`define TCR_PUMPSRC_BIT    6
`define TCR_PUMPLVL_BIT    5
`define TCR_BAND_MSB       7
`define TCR_BAND_LSB       3
`define TCR_AUTOSEL_BIT    2
`define TCR_LATCH_BIT      1
`define TCR_READ_BIT       0
`define TCR_SLEEP_BIT      7
`define TCR_FACTORY_BIT    5
`define TCR_GAIN_MSB       3
`define TCR_GAIN_LSB       0
`define TCR_PD_SYNTH_BIT   6
`define TCR_PD_DIV_BIT     5
`define TCR_PD_OSC_BIT     4
`define TCR_PD_BASE_BIT    3
`define TCR_PD_MIX_BIT     2
`define TCR_PD_RFG_BIT     1
`define TCR_PD_FE_BIT      0
`define TCR_PTST_MSB       7
`define TCR_PTST_LSB       5
`define TCR_FASTLOCK_BIT   3
`define TCR_REFOUT_MSB     2
`define TCR_REFOUT_LSB     0

// ****************************************************************
// Pump test selector codes
// ****************************************************************
`define TCR_PTST_NORMAL    3'h0
`define TCR_PTST_XTAL      3'h1
`define TCR_PTST_BOTH      3'h4
`define TCR_PTST_SRC       3'h5
`define TCR_PTST_SINK      3'h6
`define TCR_PTST_HIZ       3'h7

`endif

//--- hdl/tcr_twi_rx.v
`timescale 1ns/1ps
`include "tcr_defs.vh"

// Two-wire write receiver: start/stop detection, byte shifting and
// acknowledge drive. Reads are not acknowledged.
module tcr_twi_rx (
	input  wire       clk_sys,   // System clock.
	input  wire       rst,       // Synchronous reset, active high.
	input  wire       scl_i,     // Serial clock pin level.
	input  wire       sda_i,     // Serial data pin level.
	input  wire       addr_pin,  // Synchronised address select.
	output reg        sda_o,     // Data pin output value, always low.
	output reg        sda_oe,    // Data pin pull-down enable.
	output reg        radr_stb,  // Register address byte taken.
	output reg        data_stb,  // Data byte taken.
	output reg        stop_stb,  // Stop condition seen.
	output reg  [7:0] rx_byte    // Last byte received.
);

	localparam ST_IDLE = 2'h0;
	localparam ST_SADR = 2'h1;
	localparam ST_RADR = 2'h2;
	localparam ST_DATA = 2'h3;

	reg  [2:0] scl_q;
	reg  [2:0] sda_q;
	reg  [1:0] st_q;
	reg  [3:0] cnt_q;
	reg  [7:0] sh_q;
	wire       scl_rise;
	wire       scl_fall;
	wire       start_c;
	wire       stop_c;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	// Stage 0 feeds only stage 1; edges compare stages 1 and 2.
	always @(posedge clk_sys) begin
		if (rst) begin
			scl_q <= 3'h7;
			sda_q <= 3'h7;
		end else begin
			scl_q <= {scl_q[1:0], scl_i};
			sda_q <= {sda_q[1:0], sda_i};
		end
	end

	assign scl_rise = scl_q[1] & ~scl_q[2];
	assign scl_fall = ~scl_q[1] & scl_q[2];
	assign start_c  = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
	assign stop_c   = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

	// ****************************************************************
	// Byte engine
	// ****************************************************************
	// The acknowledge is driven from the falling edge after bit eight
	// to the next falling edge, so it is stable across the ninth high.
	always @(posedge clk_sys) begin
		if (rst) begin
			st_q     <= ST_IDLE;
			cnt_q    <= 4'h0;
			sh_q     <= 8'h00;
			sda_o    <= 1'b0;
			sda_oe   <= 1'b0;
			radr_stb <= 1'b0;
			data_stb <= 1'b0;
			stop_stb <= 1'b0;
			rx_byte  <= 8'h00;
		end else begin
			radr_stb <= 1'b0;
			data_stb <= 1'b0;
			stop_stb <= stop_c;
			if (start_c) begin
				st_q   <= ST_SADR;
				cnt_q  <= 4'h0;
				sda_oe <= 1'b0;
			end else if (stop_c) begin
				st_q   <= ST_IDLE;
				cnt_q  <= 4'h0;
				sda_oe <= 1'b0;
			end else if (st_q != ST_IDLE) begin
				if (scl_rise && cnt_q < 4'h8) begin
					sh_q  <= {sh_q[6:0], sda_q[1]};
					cnt_q <= cnt_q + 4'h1;
				end else if (scl_fall && sda_oe) begin
					sda_oe <= 1'b0;
					cnt_q  <= 4'h0;
				end else if (scl_fall && cnt_q == 4'h8) begin
					rx_byte <= sh_q;
					cnt_q   <= 4'h0;
					case (st_q)
						ST_SADR: begin
							if (sh_q == {`TCR_SLAVE_ADDR_HI, addr_pin, 1'b0}) begin
								sda_oe <= 1'b1;
								st_q   <= ST_RADR;
							end else begin
								st_q   <= ST_IDLE;
							end
						end
						ST_RADR: begin
							sda_oe   <= 1'b1;
							radr_stb <= 1'b1;
							st_q     <= ST_DATA;
						end
						ST_DATA: begin
							sda_oe   <= 1'b1;
							data_stb <= 1'b1;
						end
						default: begin
							st_q <= ST_IDLE;
						end
					endcase
				end
			end
		end
	end

endmodule // tcr_twi_rx

//--- hdl/tcr_decode.v
`timescale 1ns/1ps
`include "tcr_defs.vh"

// Combinational decode of divider and pump test codes.
module tcr_decode (
	input  wire [2:0] xdiv_code,    // Crystal output divide code.
	input  wire [4:0] rdiv_code,    // Reference divide code.
	input  wire [2:0] ptst_code,    // Pump test selector.
	output wire [3:0] xdiv_ratio,   // Crystal divide ratio.
	output wire [4:0] rdiv_ratio,   // Reference divide ratio.
	output wire       src_en,       // Pump source current enabled.
	output wire       sink_en,      // Pump sink current enabled.
	output wire       xtal_test     // Crystal translator path routed.
);

	// Maps the crystal divide code; code 010 is unlisted and is
	// treated as divide by two.
	function [3:0] xdiv_of;
		input [2:0] c;
		begin
			case (c)
				3'h0:    xdiv_of = 4'h1;
				3'h1:    xdiv_of = 4'h2;
				3'h3:    xdiv_of = 4'h3;
				3'h4:    xdiv_of = 4'h4;
				3'h5:    xdiv_of = 4'h5;
				3'h6:    xdiv_of = 4'h7;
				3'h7:    xdiv_of = 4'h8;
				default: xdiv_of = 4'h2;
			endcase
		end
	endfunction

	assign xdiv_ratio = xdiv_of(xdiv_code);
	// Code zero has no ratio; it is held at divide by one.
	assign rdiv_ratio = (rdiv_code == 5'h00) ? 5'h01 : rdiv_code;
	// Normal mode keeps both pump currents under loop control.
	assign src_en  = (ptst_code == `TCR_PTST_NORMAL) |
	                 (ptst_code == `TCR_PTST_BOTH) |
	                 (ptst_code == `TCR_PTST_SRC);
	assign sink_en = (ptst_code == `TCR_PTST_NORMAL) |
	                 (ptst_code == `TCR_PTST_BOTH) |
	                 (ptst_code == `TCR_PTST_SINK);
	assign xtal_test = (ptst_code == `TCR_PTST_XTAL);

endmodule // tcr_decode

//--- hdl/tcr_config_regs.v
// Summary of operation
// - Crystal divide selector in bits 7..5, default 000, codes map to ratios.
// - Reference divide value in bits 4..0, default 00100, 11111 divides by 31.
// - Post-divide select bit 7, default one; zero divides by two.
// - Pump source select bit 6, default one; zero lets bit 5 pick current.
// - Band index bits 7..3, default 11001, manual band or autoselect start.
// - Autoselect enable bit 2, default one; zero means manual band.
// - Converter latch follows bit 1 only while autoselect is off.
// - Converter readback follows bit 0 only while autoselect is off.
// - Filter corner code eight bits, default 01001011.
// - Standby bit 7 stops signal path and synthesizer, crystal side stays.
// - Baseband gain code bits 3..0, default 0000, about 1dB per step.
// - One power-down bit per block, default zero, one shuts it down.
// - Pump test selector decoded into source, sink and translator path.
// - Register address advances after each data byte until stop.
// - Lock indication counts only while fast-lock is one.
`timescale 1ns/1ps
`include "tcr_defs.vh"

module tcr_config_regs (
	input  wire       clk_sys,                 // System clock, 10 MHz.
	input  wire       rst,                     // Synchronous reset.
	input  wire       scl_i,                   // Serial clock pin.
	input  wire       sda_i,                   // Serial data pin in.
	output reg        sda_o,                   // Serial data pin out.
	output reg        sda_oe,                  // Serial data drive enable.
	input  wire       addr_sel_i,              // Address select pin.
	input  wire       lock_raw_i,              // Raw lock detector level.
	output reg  [2:0] crystal_out_divide,      // Crystal divide code.
	output reg  [3:0] xtal_div_ratio,          // Crystal divide ratio.
	output reg  [4:0] ref_div_value,           // Reference divide ratio.
	output reg        osc_post_divide_sel,     // 0 div 2, 1 div 4.
	output reg        pump_current_source_sel, // 1 autoselect owns pump.
	output reg        pump_current_level,      // Stored level bit.
	output reg        pump_high_current,       // Manual 1200uA in force.
	output reg  [4:0] osc_band_index,          // Band index.
	output reg        band_autoselect_en,      // Autoselect enabled.
	output reg        tune_conv_latch_en,      // Converter latch active.
	output reg        tune_conv_read_en,       // Converter readback on.
	output reg  [7:0] filter_corner_code,      // Filter corner code.
	output reg        signal_path_sleep,       // Software standby.
	output reg        factory_off_bit,         // Factory bit as stored.
	output reg  [3:0] baseband_gain_code,      // Baseband gain code.
	output reg        synth_off,               // Synthesizer stopped.
	output reg        divider_off,             // Divider stopped.
	output reg        osc_off,                 // Oscillator stopped.
	output reg        baseband_off,            // Baseband stopped.
	output reg        mixer_off,               // Mixer stopped.
	output reg        rf_gain_stage_off,       // RF gain stage stopped.
	output reg        front_end_off,           // Front end stopped.
	output reg  [2:0] pump_test_sel,           // Pump test selector.
	output reg        pump_src_en,             // Pump source enabled.
	output reg        pump_sink_en,            // Pump sink enabled.
	output reg        xtal_translator_test,    // Translator path test.
	output reg        fast_lock_en,            // Fast lock enabled.
	output reg  [2:0] refout_sel,              // Reference output select.
	output reg        lock_flag                // Qualified lock level.
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	reg  [1:0] adr_sync_q;
	reg  [1:0] lock_sync_q;
	// Write pointer and the seven stored register images.
	reg  [7:0] ptr_q;
	reg  [7:0] ref_q;
	reg  [7:0] pump_q;
	reg  [7:0] band_q;
	reg  [7:0] filt_q;
	reg  [7:0] gain_q;
	reg  [7:0] pd_q;
	reg  [7:0] test_q;
	// Receiver strobes and decoder results.
	wire       rx_sda_o;
	wire       rx_sda_oe;
	wire       radr_stb;
	wire       data_stb;
	wire [7:0] rx_byte;
	wire [3:0] dec_xdiv;
	wire [4:0] dec_rdiv;
	wire       dec_src;
	wire       dec_sink;
	wire       dec_xtal;
	// Qualifiers shared by several outputs.
	wire       sleep;
	wire       manual_band;

	// Merges a written byte into a register, keeping only live bits.
	// One function keeps the mask rule alike for all seven registers.
	function [7:0] merge;
		input [7:0] wdata;
		input [7:0] mask;
		begin
			merge = wdata & mask;
		end
	endfunction

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	// Address pin and lock level are asynchronous to the system clock.
	// Only the second stage is read by logic, so a metastable first
	// stage never reaches the receiver or the lock qualifier.
	always @(posedge clk_sys) begin
		if (rst) begin
			adr_sync_q  <= 2'h0;
			lock_sync_q <= 2'h0;
		end else begin
			adr_sync_q  <= {adr_sync_q[0], addr_sel_i};
			lock_sync_q <= {lock_sync_q[0], lock_raw_i};
		end
	end

	// ****************************************************************
	// Two-wire receiver
	// ****************************************************************
	// Only writes are decoded; read requests are left unacknowledged.
	tcr_twi_rx u_rx (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.scl_i    (scl_i),
		.sda_i    (sda_i),
		.addr_pin (adr_sync_q[1]),
		.sda_o    (rx_sda_o),
		.sda_oe   (rx_sda_oe),
		.radr_stb (radr_stb),
		.data_stb (data_stb),
		.stop_stb (),
		.rx_byte  (rx_byte)
	);

	// Pin drive is re-registered so the top outputs are flip-flops.
	// The extra stage delays the acknowledge by one clock; even at the
	// fastest bus rate the low phase leaves several clocks of margin.
	always @(posedge clk_sys) begin
		if (rst) begin
			sda_o  <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			sda_o  <= rx_sda_o;
			sda_oe <= rx_sda_oe;
		end
	end

	// ****************************************************************
	// Register pointer and register file
	// ****************************************************************
	// The pointer loads from the address byte and steps after every
	// data byte; a stop simply ends the strobes, so no clear is needed.
	// Offsets outside the writable range are acknowledged and dropped.
	// The pointer wraps at eight bits, so a long burst walks through
	// the unused offsets and comes back round to the dividers.
	always @(posedge clk_sys) begin
		if (rst) begin
			ptr_q  <= 8'h00;
			ref_q  <= `TCR_RST_REF_CLOCK_DIVIDERS;
			pump_q <= `TCR_RST_SYNTH_PUMP_CONFIG;
			band_q <= `TCR_RST_OSCILLATOR_BAND_SELECT;
			filt_q <= `TCR_RST_FILTER_CORNER;
			gain_q <= `TCR_RST_GAIN_AND_STANDBY;
			pd_q   <= `TCR_RST_BLOCK_POWER_DOWN;
			test_q <= `TCR_RST_TEST_MODES;
		end else if (radr_stb) begin
			ptr_q <= rx_byte;
		end else if (data_stb) begin
			ptr_q <= ptr_q + 8'h01;
			case (ptr_q)
				`TCR_OFS_REF_CLOCK_DIVIDERS: begin
					ref_q <= merge(rx_byte, `TCR_MSK_REF_CLOCK_DIVIDERS);
				end
				`TCR_OFS_SYNTH_PUMP_CONFIG: begin
					pump_q <= merge(rx_byte, `TCR_MSK_SYNTH_PUMP_CONFIG);
				end
				`TCR_OFS_OSCILLATOR_BAND_SELECT: begin
					band_q <= merge(rx_byte,
						`TCR_MSK_OSCILLATOR_BAND_SELECT);
				end
				`TCR_OFS_FILTER_CORNER: begin
					filt_q <= merge(rx_byte, `TCR_MSK_FILTER_CORNER);
				end
				`TCR_OFS_GAIN_AND_STANDBY: begin
					gain_q <= merge(rx_byte, `TCR_MSK_GAIN_AND_STANDBY);
				end
				`TCR_OFS_BLOCK_POWER_DOWN: begin
					pd_q <= merge(rx_byte, `TCR_MSK_BLOCK_POWER_DOWN);
				end
				`TCR_OFS_TEST_MODES: begin
					test_q <= merge(rx_byte, `TCR_MSK_TEST_MODES);
				end
				default: begin
					// Unused offset: the byte is acknowledged and dropped.
					ptr_q <= ptr_q + 8'h01;
				end
			endcase
		end
	end

	// ****************************************************************
	// Field decode
	// ****************************************************************
	tcr_decode u_dec (
		.xdiv_code  (ref_q[`TCR_XDIV_MSB:`TCR_XDIV_LSB]),
		.rdiv_code  (ref_q[`TCR_RDIV_MSB:`TCR_RDIV_LSB]),
		.ptst_code  (test_q[`TCR_PTST_MSB:`TCR_PTST_LSB]),
		.xdiv_ratio (dec_xdiv),
		.rdiv_ratio (dec_rdiv),
		.src_en     (dec_src),
		.sink_en    (dec_sink),
		.xtal_test  (dec_xtal)
	);

	// These qualifiers and the decoder results reach pins only through
	// the output stage, so a code change cannot glitch the analog side.
	assign sleep       = gain_q[`TCR_SLEEP_BIT];
	assign manual_band = ~band_q[`TCR_AUTOSEL_BIT];

	// ****************************************************************
	// Output stage
	// ****************************************************************
	// Every setting leaves through one flip-flop, one cycle after the
	// register changes; the analog side sees no decode glitches.
	// Reset values mirror the register defaults, so the settings seen
	// during reset equal those seen right after it is released.
	always @(posedge clk_sys) begin
		if (rst) begin
			crystal_out_divide      <= 3'h0;
			xtal_div_ratio          <= 4'h1;
			ref_div_value           <= 5'h04;
			osc_post_divide_sel     <= 1'b1;
			pump_current_source_sel <= 1'b1;
			pump_current_level      <= 1'b0;
			pump_high_current       <= 1'b0;
			osc_band_index          <= 5'h19;
			band_autoselect_en      <= 1'b1;
			tune_conv_latch_en      <= 1'b0;
			tune_conv_read_en       <= 1'b0;
			filter_corner_code      <= `TCR_RST_FILTER_CORNER;
			signal_path_sleep       <= 1'b0;
			factory_off_bit         <= 1'b0;
			baseband_gain_code      <= 4'h0;
			synth_off               <= 1'b0;
			divider_off             <= 1'b0;
			osc_off                 <= 1'b0;
			baseband_off            <= 1'b0;
			mixer_off               <= 1'b0;
			rf_gain_stage_off       <= 1'b0;
			front_end_off           <= 1'b0;
			pump_test_sel           <= 3'h0;
			pump_src_en             <= 1'b1;
			pump_sink_en            <= 1'b1;
			xtal_translator_test    <= 1'b0;
			fast_lock_en            <= 1'b1;
			refout_sel              <= 3'h0;
			lock_flag               <= 1'b0;
		end else begin
			// Divider settings and their decoded ratios.
			crystal_out_divide <= ref_q[`TCR_XDIV_MSB:`TCR_XDIV_LSB];
			xtal_div_ratio     <= dec_xdiv;
			ref_div_value      <= dec_rdiv;
			osc_post_divide_sel     <= pump_q[`TCR_POSTDIV_BIT];
			pump_current_source_sel <= pump_q[`TCR_PUMPSRC_BIT];
			pump_current_level      <= pump_q[`TCR_PUMPLVL_BIT];
			// The level bit only matters when autoselect does not own it.
			// The stored level is still exported for the analog side.
			pump_high_current <= ~pump_q[`TCR_PUMPSRC_BIT] &
			                     pump_q[`TCR_PUMPLVL_BIT];
			osc_band_index     <= band_q[`TCR_BAND_MSB:`TCR_BAND_LSB];
			band_autoselect_en <= band_q[`TCR_AUTOSEL_BIT];
			tune_conv_latch_en <= manual_band & band_q[`TCR_LATCH_BIT];
			tune_conv_read_en  <= manual_band & band_q[`TCR_READ_BIT];
			filter_corner_code <= filt_q;
			signal_path_sleep  <= sleep;
			// Stored as written; only zero is a characterised value.
			factory_off_bit    <= gain_q[`TCR_FACTORY_BIT];
			baseband_gain_code <= gain_q[`TCR_GAIN_MSB:`TCR_GAIN_LSB];
			// Standby folds into every synthesizer and signal path block;
			// the crystal and reference output logic is left running.
			// Sleep is kept out of the power-down image, so leaving
			// standby restores exactly the blocks that ran before.
			synth_off         <= pd_q[`TCR_PD_SYNTH_BIT] | sleep;
			divider_off       <= pd_q[`TCR_PD_DIV_BIT] | sleep;
			osc_off           <= pd_q[`TCR_PD_OSC_BIT] | sleep;
			baseband_off      <= pd_q[`TCR_PD_BASE_BIT] | sleep;
			mixer_off         <= pd_q[`TCR_PD_MIX_BIT] | sleep;
			rf_gain_stage_off <= pd_q[`TCR_PD_RFG_BIT] | sleep;
			front_end_off     <= pd_q[`TCR_PD_FE_BIT] | sleep;
			pump_test_sel        <= test_q[`TCR_PTST_MSB:`TCR_PTST_LSB];
			pump_src_en          <= dec_src;
			pump_sink_en         <= dec_sink;
			xtal_translator_test <= dec_xtal;
			fast_lock_en         <= test_q[`TCR_FASTLOCK_BIT];
			refout_sel <= test_q[`TCR_REFOUT_MSB:`TCR_REFOUT_LSB];
			// Without fast lock the detector output is meaningless.
			// A lock level seen while fast lock is off is dropped.
			lock_flag  <= lock_sync_q[1] & test_q[`TCR_FASTLOCK_BIT];
		end
	end

endmodule // tcr_config_regs

//--- test/tcr_twi_host.sv
`timescale 1ns/1ps
// Bus master model; both lines idle released and the clock stands still.
module tcr_twi_host (
	input  wire clk_sys, // Paces the bus.
	input  wire sda_in,  // Resolved data line.
	output reg  scl,     // Serial clock.
	output reg  sda_drv  // Zero pulls data low.
);
	// Eight clocks a phase keeps clear of the five-clock minimum.
	task half;
		repeat (8) @(negedge clk_sys);
	endtask
	task start;
		begin
			sda_drv = 1'b0;
			half;
			scl = 1'b0;
			half;
		end
	endtask
	// Data moves only mid-low so it never looks like a frame edge.
	task send(input [7:0] b, output ack);
		integer i;
		begin
			for (i = 8; i >= 0; i = i - 1) begin
				sda_drv = (i == 0) ? 1'b1 : b[i-1];
				half;
				scl = 1'b1;
				half;
				ack = ~sda_in;
				scl = 1'b0;
				half;
			end
		end
	endtask
	task stop;
		begin
			sda_drv = 1'b0;
			half;
			scl = 1'b1;
			half;
			sda_drv = 1'b1;
			half;
		end
	endtask
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
endmodule // tcr_twi_host

//--- test/tcr_config_regs_asserts.sv
`timescale 1ns/1ps
// Checker on the configuration outputs and the acknowledge drive.
module tcr_config_regs_chk (
	input wire       clk_sys,
	input wire       rst,
	input wire       scl_i,
	input wire       sda_o,
	input wire       sda_oe,
	input wire       lock_raw_i,
	input wire       lock_flag,
	input wire       fast_lock_en,
	input wire       pump_current_source_sel,
	input wire       pump_current_level,
	input wire       pump_high_current,
	input wire       band_autoselect_en,
	input wire       tune_conv_latch_en,
	input wire       tune_conv_read_en,
	input wire [7:0] filter_corner_code,
	input wire       signal_path_sleep,
	input wire       synth_off,
	input wire       front_end_off,
	input wire [2:0] pump_test_sel,
	input wire       pump_src_en,
	input wire       pump_sink_en,
	input wire       xtal_translator_test
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	latch_gate_a: assert property (
		tune_conv_latch_en |-> !band_autoselect_en) else $error("latch gate");
	read_gate_a: assert property (
		tune_conv_read_en |-> !band_autoselect_en) else $error("read gate");
	sleep_off_a: assert property (
		signal_path_sleep |-> synth_off && front_end_off) else $error("sleep");
	pump_level_a: assert property (
		pump_high_current == (!pump_current_source_sel && pump_current_level))
		else $error("pump level");
	lock_qual_a: assert property (
		$rose(lock_flag) |-> fast_lock_en && $past(lock_raw_i, 3))
		else $error("lock flag");
	ack_low_a: assert property (
		$rose(sda_oe) |-> !scl_i && !sda_o) else $error("ack edge");
	ack_hold_a: assert property (
		$rose(scl_i) && sda_oe |-> sda_oe [*8]) else $error("ack hold");
	pump_hiz_a: assert property (
		pump_test_sel == 3'h7 |-> !pump_src_en && !pump_sink_en &&
		!xtal_translator_test) else $error("pump hiz");
	cfg_on_ack_a: assert property (
		$changed(filter_corner_code) |-> $past(sda_oe) || $past(sda_oe, 2))
		else $error("write without ack");
endmodule // tcr_config_regs_chk

bind tcr_config_regs tcr_config_regs_chk i_tcr_config_regs_chk (
	.clk_sys(clk_sys), .rst(rst), .scl_i(scl_i), .sda_o(sda_o),
	.sda_oe(sda_oe), .lock_raw_i(lock_raw_i), .lock_flag(lock_flag),
	.fast_lock_en(fast_lock_en),
	.pump_current_source_sel(pump_current_source_sel),
	.pump_current_level(pump_current_level),
	.pump_high_current(pump_high_current),
	.band_autoselect_en(band_autoselect_en),
	.tune_conv_latch_en(tune_conv_latch_en),
	.tune_conv_read_en(tune_conv_read_en),
	.filter_corner_code(filter_corner_code),
	.signal_path_sleep(signal_path_sleep), .synth_off(synth_off),
	.front_end_off(front_end_off), .pump_test_sel(pump_test_sel),
	.pump_src_en(pump_src_en), .pump_sink_en(pump_sink_en),
	.xtal_translator_test(xtal_translator_test));

//--- test/tcr_config_regs_test.sv
`timescale 1ns/1ps
`include "tcr_defs.vh"
// Self-checking bench; every register is reached over the two-wire bus.
module tcr_config_regs_test;
	reg         clk_sys = 1'b0;
	reg         rst = 1'b1;
	reg         addr_sel_i = 1'b0;
	reg         lock_raw_i = 1'b0;
	integer     fails = 0;
	integer     n_compared = 0;
	integer     i;
	reg         ack;
	wire        scl, sda_drv, sda_o, sda_oe;
	wire [3:0]  xr, gn;
	wire [4:0]  rr, bd;
	wire [7:0]  fc;
	wire [6:0]  off;
	wire        pd, ps, ph, va, la, rd, sl, se, sk, xt, fl, lk, fb;
	wire [2:0]  cx, rs;
	// Open-drain data line with its pull-up.
	wire        sda = sda_drv & ~(sda_oe & ~sda_o);
	localparam [17:0] codes = 18'h01977;
	localparam [17:0] exps = 18'h31D10;

	always #50 clk_sys = ~clk_sys;

	tcr_twi_host i_tcr_twi_host (.clk_sys(clk_sys), .sda_in(sda),
		.scl(scl), .sda_drv(sda_drv));
	tcr_config_regs i_tcr_config_regs (.clk_sys(clk_sys), .rst(rst),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
		.addr_sel_i(addr_sel_i), .lock_raw_i(lock_raw_i),
		.crystal_out_divide(cx), .xtal_div_ratio(xr), .ref_div_value(rr),
		.osc_post_divide_sel(pd), .pump_current_source_sel(ps),
		.pump_current_level(), .pump_high_current(ph),
		.osc_band_index(bd), .band_autoselect_en(va),
		.tune_conv_latch_en(la), .tune_conv_read_en(rd),
		.filter_corner_code(fc), .signal_path_sleep(sl),
		.factory_off_bit(fb), .baseband_gain_code(gn), .synth_off(off[6]),
		.divider_off(off[5]), .osc_off(off[4]), .baseband_off(off[3]),
		.mixer_off(off[2]), .rf_gain_stage_off(off[1]),
		.front_end_off(off[0]), .pump_test_sel(), .pump_src_en(se),
		.pump_sink_en(sk), .xtal_translator_test(xt), .fast_lock_en(fl),
		.refout_sel(rs), .lock_flag(lk));

	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	// Burst write of n bytes from register a, most significant first.
	task wr(input [7:0] a, input [55:0] d, input integer n);
		integer k;
		begin
			i_tcr_twi_host.start;
			i_tcr_twi_host.send({`TCR_SLAVE_ADDR_HI, addr_sel_i, 1'b0}, ack);
			chk(ack, 1'b1);
			i_tcr_twi_host.send(a, ack);
			chk(ack, 1'b1);
			for (k = n - 1; k >= 0; k = k - 1) begin
				i_tcr_twi_host.send(d[8*k+:8], ack);
				chk(ack, 1'b1);
			end
			i_tcr_twi_host.stop;
		end
	endtask
	task report_and_stop;
		begin
			if (fails == 0 && n_compared > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	// A hung bus would otherwise stall the run forever.
	initial begin
		#5000000;
		fails = fails + 1;
		report_and_stop;
	end
	initial begin
		repeat (8) @(negedge clk_sys);
		rst = 1'b0;
		repeat (1000) @(negedge clk_sys);
		chk({xr, rr, pd, ps, ph, bd, va, la, rd}, 20'h126CC);
		chk({fc, sl, gn, off}, 20'h4B000);
		chk({se, sk, xt, fl, lk}, 5'h1A);
		chk({cx, fb, rs}, 7'h00);
		wr(8'h05, 56'hFF200B0C5F7FE8, 7);
		chk({xr, rr, pd, ps, ph, bd, va, la, rd}, 20'h8F90B);
		chk({fc, sl, gn, off}, 20'h0C7FF);
		chk({cx, fb, rs}, 7'h70);
		wr(8'h07, 8'hCF, 1);
		chk({bd, va, la, rd}, 8'hCC);
		for (i = 0; i < 6; i = i + 1) begin
			wr(8'h0B, {codes[3*(5-i)+:3], 5'h08}, 1);
			chk({se, sk, xt}, exps[3*(5-i)+:3]);
		end
		wr(8'h09, 16'h8000, 2);
		chk({sl, off}, 8'hFF);
		wr(8'h09, 16'h0F00, 2);
		chk({sl, gn, off}, 12'h780);
		lock_raw_i = 1'b1;
		repeat (6) @(negedge clk_sys);
		chk(lk, 1'b1);
		wr(8'h0B, 8'h00, 1);
		chk({lk, se, sk}, 3'h3);
		i_tcr_twi_host.start;
		i_tcr_twi_host.send({`TCR_SLAVE_ADDR_HI, 1'b1, 1'b0}, ack);
		i_tcr_twi_host.stop;
		chk(ack, 1'b0);
		addr_sel_i = 1'b1;
		wr(8'h08, 8'h55, 1);
		chk(fc, 8'h55);
		report_and_stop;
	end
endmodule // tcr_config_regs_test
